// ---- dram_refresh_controller.sv ----
`timescale 1ns/100ps
`default_nettype none
module dram_refresh_controller (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // I/O register port
   input wire refresh_pkg::reg_wr_t io_wr_i,
   input wire logic [7:0] io_rd_addr_i,
   output logic [7:0] io_rd_data_o,
   // CPU state
   input wire logic bus_request_in_i,
   input wire logic sleep_i,
   input wire logic wait_i,
   input wire logic mcycle_end_i,
   // Refresh bus cycle
   output logic refresh_o,
   output logic refresh_wait_state_o,
   output logic [7:0] refresh_addr_o
);
   import refresh_pkg::*;

   // ****************************************
   // Control register
   // ****************************************
   logic [7:0] refresh_ctrl_reg_r;
   logic refresh_enable;
   logic refresh_wait_select;
   logic [1:0] refresh_interval_select;

   // Only implemented bits are stored, others read as zero
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         refresh_ctrl_reg_r <= REFRESH_CTRL_RESET;
      end else if (io_wr_i.wr && io_wr_i.addr == REFRESH_CTRL_OFFSET) begin
         refresh_ctrl_reg_r <= io_wr_i.data & REFRESH_CTRL_MASK;
      end
   end

   assign refresh_enable = refresh_ctrl_reg_r[ENABLE_BIT];
   assign refresh_wait_select = refresh_ctrl_reg_r[WAIT_SEL_BIT];
   assign refresh_interval_select = refresh_ctrl_reg_r[INTERVAL_LSB +: 2];

   // Read data registered
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         io_rd_data_o <= 8'h00;
      end else if (io_rd_addr_i == REFRESH_CTRL_OFFSET) begin
         io_rd_data_o <= refresh_ctrl_reg_r;
      end else begin
         io_rd_data_o <= 8'h00;
      end
   end

   // ****************************************
   // Interval timer
   // ****************************************
   logic tick;

   interval_timer u_timer (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .interval_sel_i(refresh_interval_select),
      .tick_o(tick)
   );

   // ****************************************
   // Request and sleep latch
   // ****************************************
   logic pending_r;
   logic sleep_latch_r;
   logic was_sleep_r;
   logic wake_armed_r;
   logic blocked;
   logic start;
   logic done;
   refresh_state_t state_r;
   logic [1:0] cyc_cnt_r;

   // Bus release and waits hold insertion off
   assign blocked = bus_request_in_i || wait_i || sleep_i;

   // A request dropped during bus release is lost, not queued
   // A fresh tick wins over the clear so a request is only swallowed during bus release
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         pending_r <= 1'b0;
      end else if (tick && refresh_enable && !sleep_i) begin
         pending_r <= !bus_request_in_i;
      end else if (start || bus_request_in_i || !refresh_enable) begin
         pending_r <= 1'b0;
      end
   end

   // One-deep latch; a later sleep request just rewrites it
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         sleep_latch_r <= 1'b0;
      end else if (sleep_i && tick && refresh_enable) begin
         sleep_latch_r <= 1'b1;
      end else if (start && wake_armed_r) begin
         sleep_latch_r <= 1'b0;
      end else if (!refresh_enable) begin
         sleep_latch_r <= 1'b0;
      end
   end

   // Replay waits for the first machine cycle end after wake
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         was_sleep_r <= 1'b0;
         wake_armed_r <= 1'b0;
      end else begin
         was_sleep_r <= sleep_i;
         if (was_sleep_r && !sleep_i && sleep_latch_r) begin
            wake_armed_r <= 1'b1;
         end else if (start) begin
            wake_armed_r <= 1'b0;
         end
      end
   end

   // Start at a machine cycle end when not blocked
   assign start = (state_r == ST_IDLE) && !reset_i && !blocked && refresh_enable
      && mcycle_end_i && (pending_r || (wake_armed_r && sleep_latch_r));

   // ****************************************
   // Refresh cycle
   // ****************************************
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         state_r <= ST_IDLE;
         cyc_cnt_r <= 2'd0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (start) begin
                  state_r <= ST_CYCLE;
                  cyc_cnt_r <= 2'd1;
               end
            end
            ST_CYCLE: begin
               if (done) begin
                  state_r <= ST_IDLE;
                  cyc_cnt_r <= 2'd0;
               end else begin
                  cyc_cnt_r <= cyc_cnt_r + 2'd1;
               end
            end
            default: begin
               state_r <= ST_IDLE;
               cyc_cnt_r <= 2'd0;
            end
         endcase
      end
   end

   // Length is sampled live; software should not change it mid cycle
   assign done = (state_r == ST_CYCLE) &&
      (cyc_cnt_r == (refresh_wait_select ? CYCLE_LONG : CYCLE_SHORT));

   assign refresh_o = (state_r == ST_CYCLE);
   assign refresh_wait_state_o = refresh_o && refresh_wait_select &&
      (cyc_cnt_r == CYCLE_LONG);

   // Address moves only once a bus cycle has finished
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         refresh_addr_o <= 8'h00;
      end else if (done) begin
         refresh_addr_o <= refresh_addr_o + 8'h01;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_no_refresh_off: assert property (@(posedge core_clk_i) disable iff (reset_i)
      !refresh_enable |=> !$rose(refresh_o))
      else $error("refresh started while disabled");

   a_long_cycle: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (start && refresh_wait_select) |=> refresh_o [*3] ##1 !refresh_o)
      else $error("three clock refresh length wrong");

   a_short_cycle: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (start && !refresh_wait_select) |=> refresh_o [*2] ##1 !refresh_o)
      else $error("two clock refresh length wrong");

   // Only checked once reset has gone, so the very first edge is not judged
   a_reset_value: assert property (@(posedge core_clk_i)
      ($past(reset_i) && !reset_i) |-> (refresh_ctrl_reg_r == REFRESH_CTRL_RESET
      && !refresh_o && refresh_addr_o == 8'h00))
      else $error("reset values wrong");

   a_blocked_start: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (bus_request_in_i || sleep_i || wait_i) |=> !$rose(refresh_o))
      else $error("refresh inserted while blocked");

   a_addr_step: assert property (@(posedge core_clk_i) disable iff (reset_i)
      done |=> refresh_addr_o == $past(refresh_addr_o) + 8'h01)
      else $error("refresh address did not step");

   a_addr_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
      !done |=> $stable(refresh_addr_o))
      else $error("refresh address moved without a cycle");

   a_sleep_latch: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (sleep_i && tick && refresh_enable) |=> sleep_latch_r)
      else $error("sleep request not latched");

   a_wake_replay: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (wake_armed_r && sleep_latch_r && mcycle_end_i && !blocked && refresh_enable
       && state_r == ST_IDLE) |=> refresh_o)
      else $error("post sleep refresh not replayed");

endmodule : dram_refresh_controller
`default_nettype wire

// ---- refresh_pkg.sv ----
package refresh_pkg;

   // ****************************************
   // Register map and fields
   // ****************************************
   localparam logic [7:0] REFRESH_CTRL_OFFSET = 8'h36;
   localparam int ENABLE_BIT = 7;
   localparam int WAIT_SEL_BIT = 6;
   localparam int INTERVAL_LSB = 0;
   localparam logic [7:0] REFRESH_CTRL_RESET = 8'hc0;
   localparam logic [7:0] REFRESH_CTRL_MASK = 8'hc3;

   // ****************************************
   // Timing
   // ****************************************
   localparam logic [6:0] INTERVAL_10 = 7'd10;
   localparam logic [6:0] INTERVAL_20 = 7'd20;
   localparam logic [6:0] INTERVAL_40 = 7'd40;
   localparam logic [6:0] INTERVAL_80 = 7'd80;
   localparam logic [1:0] CYCLE_SHORT = 2'd2;
   localparam logic [1:0] CYCLE_LONG = 2'd3;
   localparam int REFRESH_ADDR_W = 8;

   // Register write strobe carrier
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_wr_t;

   // Refresh cycle state machine
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CYCLE = 2'b01
   } refresh_state_t;

endpackage : refresh_pkg

// ---- interval_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
module interval_timer (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // Control
   input wire logic [1:0] interval_sel_i,
   // Request pulse
   output logic tick_o
);
   import refresh_pkg::*;

   logic [6:0] count_r;
   logic [6:0] limit;

   // Decode the selected state count
   always_comb begin
      case (interval_sel_i)
         2'b00: limit = INTERVAL_10;
         2'b01: limit = INTERVAL_20;
         2'b10: limit = INTERVAL_40;
         default: limit = INTERVAL_80;
      endcase
   end

   // Free running so bus release and sleep never disturb the phase
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         count_r <= 7'd0;
      end else if (count_r >= limit - 7'd1) begin
         count_r <= 7'd0;
      end else begin
         count_r <= count_r + 7'd1;
      end
   end

   assign tick_o = !reset_i && (count_r >= limit - 7'd1);

   // Request comes exactly every limit cycles
   a_tick_period: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (tick_o && $stable(interval_sel_i) && interval_sel_i == 2'b00) |=>
      !tick_o [*8] ##1 !tick_o ##1 (tick_o || interval_sel_i != 2'b00))
      else $error("interval timer period wrong");

endmodule : interval_timer
`default_nettype wire

// ---- dram_array_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module dram_array_model (
   // Refresh bus from the controller
   input wire logic core_clk_i,
   input wire logic refresh_i,
   input wire logic [7:0] row_i,
   // Last row restored
   output logic [7:0] last_row_o
);
   logic seen_r = 1'b0;
   // A row is restored once per cycle, taken at its first clock
   always @(posedge core_clk_i) begin
      seen_r <= refresh_i;
      if (refresh_i && !seen_r) begin
         last_row_o <= row_i;
      end
   end
endmodule : dram_array_model
`default_nettype wire

// ---- dram_refresh_controller_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module dram_refresh_controller_bench;
   import refresh_pkg::*;
   // ****
   // Signals and model state
   // ****
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   reg_wr_t io_wr_i = '0;
   logic [7:0] io_rd_addr_i = 8'h00;
   logic bus_request_in_i = 1'b0;
   logic sleep_i = 1'b0;
   logic wait_i = 1'b0;
   logic mcycle_end_i = 1'b1;
   logic [7:0] io_rd_data_o;
   logic refresh_o;
   logic refresh_wait_state_o;
   logic [7:0] refresh_addr_o;
   logic [7:0] last_row;
   logic [7:0] exp_addr = 8'h00;
   logic [7:0] ctrl = 8'hc0;
   int bad_count = 0;
   int comparisons = 0;
   int cyc = 0;
   int last_rise = 0;
   int rises = 0;
   int hi = 0;
   int ws = 0;
   int skip = 0;
   dram_refresh_controller i_dram_refresh_controller (.core_clk_i(core_clk_i),
      .reset_i(reset_i), .io_wr_i(io_wr_i), .io_rd_addr_i(io_rd_addr_i),
      .io_rd_data_o(io_rd_data_o), .bus_request_in_i(bus_request_in_i),
      .sleep_i(sleep_i), .wait_i(wait_i), .mcycle_end_i(mcycle_end_i),
      .refresh_o(refresh_o), .refresh_wait_state_o(refresh_wait_state_o),
      .refresh_addr_o(refresh_addr_o));
   dram_array_model i_dram_array_model (.core_clk_i(core_clk_i),
      .refresh_i(refresh_o), .row_i(refresh_addr_o), .last_row_o(last_row));
   // 10 MHz clock
   always #50 core_clk_i = ~core_clk_i;
   // ****
   // Tasks
   // ****
   task automatic check(input logic [7:0] got, input logic [7:0] want);
      comparisons++;
      if (got !== want) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, want);
      end
   endtask : check
   task automatic finish_test();
      if (bad_count == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test
   // First refresh after a write may use either setting, so skip its length
   task automatic wr(input logic [7:0] d);
      @(posedge core_clk_i);
      io_wr_i <= '{wr: 1'b1, addr: REFRESH_CTRL_OFFSET, data: d};
      @(posedge core_clk_i);
      io_wr_i.wr <= 1'b0;
      ctrl = d & REFRESH_CTRL_MASK;
      skip = 1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] want);
      @(posedge core_clk_i);
      io_rd_addr_i <= a;
      repeat (2) @(posedge core_clk_i);
      check(io_rd_data_o, want);
   endtask : rd
   task automatic gap(input int n);
      int r;
      int t;
      r = rises;
      wait (rises == r + 1);
      t = last_rise;
      wait (rises == r + 2);
      check(8'(last_rise - t), 8'(n));
   endtask : gap
   task automatic quiet(input int n);
      int r;
      r = rises;
      repeat (n) @(posedge core_clk_i);
      check(8'(rises - r), 8'h00);
   endtask : quiet
   // Block by bus release (k=0) or sleep (k=1) across two 80-state ticks
   task automatic blk(input int k);
      int r;
      int t;
      r = rises;
      wait (rises == r + 1);
      t = last_rise;
      repeat (5) @(posedge core_clk_i);
      bus_request_in_i <= (k == 0);
      sleep_i <= (k == 1);
      while (cyc < t + 170) @(posedge core_clk_i);
      bus_request_in_i <= 1'b0;
      sleep_i <= 1'b0;
      mcycle_end_i <= 1'b0;
      repeat (10) @(posedge core_clk_i);
      check(8'(rises - r), 8'h01);
      mcycle_end_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      check(8'(rises - r), 8'(k + 1));
      wait (rises == r + 2 + k);
      check(8'(last_rise - t), 8'hf0);
   endtask : blk
   // ****
   // Monitor: address of every refresh, length and wait state unless skip is set
   // ****
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (refresh_o === 1'b1) begin
         if (hi == 0) begin
            check(refresh_addr_o, exp_addr);
            exp_addr = exp_addr + 8'h01;
            last_rise = cyc;
            rises = rises + 1;
         end
         hi = hi + 1;
         ws = ws + int'(refresh_wait_state_o === 1'b1);
      end else if (hi > 0) begin
         if (skip == 0) begin
            check(8'(hi), ctrl[6] ? 8'h03 : 8'h02);
            check(8'(ws), {7'h00, ctrl[6]});
         end
         skip = 0;
         hi = 0;
         ws = 0;
      end
   end
   // Watchdog well beyond the roughly 1500 cycles the tests need
   initial begin
      repeat (20000) @(posedge core_clk_i);
      bad_count++;
      finish_test();
   end
   // ****
   // Main sequence
   // ****
   initial begin
      logic [7:0] d;
      void'($urandom(32'h56503dff));
      repeat (8) @(posedge core_clk_i);
      reset_i <= 1'b0;
      rd(REFRESH_CTRL_OFFSET, REFRESH_CTRL_RESET);
      gap(10);
      rd(8'h37, 8'h00);
      // All four intervals stay under the DRAM limit at 10 MHz
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom);
         d[7] = 1'b1;
         d[1:0] = i[1:0];
         wr(d);
         rd(REFRESH_CTRL_OFFSET, d & REFRESH_CTRL_MASK);
         gap(10 << i);
      end
      wr(8'hc0);
      gap(10);
      wait_i <= 1'b1;
      quiet(150);
      wait_i <= 1'b0;
      wr(8'h40);
      repeat (4) @(posedge core_clk_i);
      quiet(200);
      wr(8'hc3);
      blk(0);
      blk(1);
      // Reset cuts the refresh just started, so its length is not judged
      skip = 1;
      reset_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      quiet(30);
      exp_addr = 8'h00;
      ctrl = 8'hc0;
      reset_i <= 1'b0;
      rd(REFRESH_CTRL_OFFSET, REFRESH_CTRL_RESET);
      gap(10);
      // The model takes the row on the rise edge, so look once it has settled
      @(negedge core_clk_i);
      check(last_row, exp_addr - 8'h01);
      finish_test();
   end
endmodule : dram_refresh_controller_bench
`default_nettype wire
